// [core/mrca_coil_access.sv]
// Modbus RTU slave request interpreter: coil and register functions
`timescale 1ns/1ps
module mrca_coil_access
   import mrca_pkg::*;
#(
   parameter bit HAS_COILS  = 1'b1,   // Zero for the eight-channel analog model
   parameter int COIL_DEPTH = 64,
   parameter int REG_DEPTH  = 64
)
(
   input  wire logic                  core_clk,
   input  wire logic                  reset_n,
   input  wire logic [7:0]            dev_addr,
   input  wire logic                  rx_valid,
   input  wire logic [7:0]            rx_data,
   input  wire logic                  rx_frame_end,
   output logic                       tx_valid,
   output logic [7:0]                 tx_data,
   input  wire logic                  tx_ready,
   output logic [COIL_DEPTH-1:0]      coil_state,
   output logic                       busy,
   output logic                       frame_drop
);

   localparam int CW = $clog2(COIL_DEPTH);
   localparam int RW = $clog2(REG_DEPTH);

   mrca_state_t           state_ff,   nxt_state;
   logic [7:0]            rx_buf_ff [RX_DEPTH];
   logic [8:0]            rx_cnt_ff,  nxt_rx_cnt;
   logic                  rx_ovf_ff,  nxt_rx_ovf;
   logic [15:0]           rx_crc_ff,  nxt_rx_crc;
   logic [6:0]            widx_ff,    nxt_widx;
   logic [7:0]            pos_ff,     nxt_pos;
   logic [7:0]            tx_data_ff, nxt_tx_data;
   logic [15:0]           tx_crc_ff,  nxt_tx_crc;
   logic                  drop_ff,    nxt_drop;
   logic [COIL_DEPTH-1:0] coils_ff,   nxt_coils;
   logic [15:0]           regs_ff [REG_DEPTH];
   logic [15:0]           rx_crc_upd, tx_crc_upd;
   logic                  buf_we,     coil_we,  coil_wd, reg_we;
   logic [CW-1:0]         coil_wa;
   logic [RW-1:0]         reg_wa;
   logic [15:0]           reg_wd;

   // ==========================================================
   // Running frame checks for the receive and send directions
   mrca_crc16_step u_rx_crc (
      .crc_in  (rx_crc_ff),
      .data_in (rx_data),
      .crc_out (rx_crc_upd)
   );

   mrca_crc16_step u_tx_crc (
      .crc_in  (tx_crc_ff),
      .data_in (tx_data_ff),
      .crc_out (tx_crc_upd)
   );

   // ==========================================================
   // Request field decode, valid while the buffer holds a frame
   logic [7:0]  fc;
   logic [15:0] start, qty, qty_eff, nbytes, two_qty, len16;
   logic [7:0]  body_len;
   logic        is_coil_fc, is_write, is_read_reg, supported;
   logic        frame_ok, range_ok, bound_ok, len_ok, val_ok, accept;

   assign fc      = rx_buf_ff[OFS_FC];
   assign start   = {rx_buf_ff[OFS_START_HI], rx_buf_ff[OFS_START_LO]};
   assign qty     = {rx_buf_ff[OFS_QTY_HI], rx_buf_ff[OFS_QTY_LO]};
   assign nbytes  = {3'h0, qty[15:3]} + {15'h0000, |qty[2:0]};
   assign two_qty = {qty[14:0], 1'b0};
   assign len16   = {7'h00, rx_cnt_ff};
   assign qty_eff = (fc == FC_WR_COIL || fc == FC_WR_REG) ? QTY_MIN : qty;

   // Coil codes are gated off entirely on the analog model
   always_comb
   begin
      is_coil_fc  = (fc == FC_RD_COILS) || (fc == FC_WR_COIL) || (fc == FC_WR_COILS);
      is_read_reg = (fc == FC_RD_HOLD) || (fc == FC_RD_INPUT);
      is_write    = (fc == FC_WR_COIL) || (fc == FC_WR_REG) ||
                    (fc == FC_WR_COILS) || (fc == FC_WR_REGS);
      supported   = (is_coil_fc || is_read_reg || fc == FC_WR_REG ||
                     fc == FC_WR_REGS) &&
                    (HAS_COILS || !is_coil_fc);
   end

   // Acceptance: anything failing here is dropped silently, no state touched
   always_comb
   begin
      frame_ok = !rx_ovf_ff && (len16 >= LEN_MIN) && (rx_crc_ff == CRC_RESIDUE) &&
                 (dev_addr != ADDR_NONE) && (rx_buf_ff[OFS_ADDR] == dev_addr);
      range_ok = (qty_eff >= QTY_MIN) && (qty_eff <= QTY_MAX);
      bound_ok = ({1'b0, start} + {1'b0, qty_eff}) <=
                 (is_coil_fc ? 17'(COIL_DEPTH) : 17'(REG_DEPTH));
      val_ok   = (fc != FC_WR_COIL) || (qty == COIL_ON) || (qty == COIL_OFF);
      case (fc)
         FC_WR_COILS: len_ok = (len16 == LEN_WMULTI + nbytes) &&
                               (rx_buf_ff[OFS_NBYTES] == nbytes[7:0]);
         FC_WR_REGS:  len_ok = (len16 == LEN_WMULTI + two_qty) &&
                               (rx_buf_ff[OFS_NBYTES] == two_qty[7:0]);
         default:     len_ok = (len16 == LEN_FIXED);
      endcase
      accept = frame_ok && supported && range_ok && bound_ok && len_ok && val_ok;
   end

   // Reply body length, check bytes excluded
   always_comb
   begin
      if (fc == FC_RD_COILS)
         body_len = READ_HDR_LEN + nbytes[7:0];
      else if (is_read_reg)
         body_len = READ_HDR_LEN + two_qty[7:0];
      else
         body_len = ECHO_LEN;
   end

   // ==========================================================
   // Reply byte at position q; crc is the check over the body so far
   function automatic logic [7:0] reply_byte(input logic [7:0]  q,
                                             input logic [15:0] crc);
      logic [7:0]  r;
      logic [7:0]  k;
      logic [15:0] p;
      r = 8'h00;
      k = q - READ_HDR_LEN;
      if (q == body_len)
         r = crc[7:0];
      else if (q == body_len + 8'h01)
         r = crc[15:8];
      else if (q < OFS_START_HI || is_write)
         r = rx_buf_ff[q];
      else if (q == OFS_START_HI)
         r = (fc == FC_RD_COILS) ? nbytes[7:0] : two_qty[7:0];
      else if (fc == FC_RD_COILS)
      begin
         for (int j = 0; j < 8; j++)
         begin
            p = {5'h00, k, 3'h0} + 16'(j);
            // Bits past the requested count stay zero
            if (p < qty)
               r[j] = coils_ff[CW'(start + p)];
         end
      end
      else
         r = k[0] ? regs_ff[RW'(start + {9'h000, k[7:1]})][7:0]
                  : regs_ff[RW'(start + {9'h000, k[7:1]})][15:8];
      return r;
   endfunction : reply_byte

   // ==========================================================
   // Interpreter sequencing: receive, check, execute writes, send
   always_comb
   begin
      nxt_state   = state_ff;
      nxt_rx_cnt  = rx_cnt_ff;
      nxt_rx_ovf  = rx_ovf_ff;
      nxt_rx_crc  = rx_crc_ff;
      nxt_widx    = widx_ff;
      nxt_pos     = pos_ff;
      nxt_tx_data = tx_data_ff;
      nxt_tx_crc  = tx_crc_ff;
      nxt_drop    = 1'b0;
      buf_we      = 1'b0;
      coil_we     = 1'b0;
      coil_wa     = '0;
      coil_wd     = 1'b0;
      reg_we      = 1'b0;
      reg_wa      = '0;
      reg_wd      = 16'h0000;
      case (state_ff)
         ST_IDLE:
         begin
            // An over-long frame is flagged, never wrapped into the buffer
            if (rx_valid)
            begin
               if (rx_cnt_ff < 9'(RX_DEPTH))
               begin
                  buf_we     = 1'b1;
                  nxt_rx_cnt = rx_cnt_ff + 9'h001;
                  nxt_rx_crc = rx_crc_upd;
               end
               else
                  nxt_rx_ovf = 1'b1;
            end
            if (rx_frame_end && (rx_cnt_ff != 9'h000 || rx_valid))
               nxt_state = ST_CHECK;
         end
         ST_CHECK:
         begin
            if (accept && is_write)
            begin
               nxt_state = ST_EXEC;
               nxt_widx  = 7'h00;
            end
            else if (accept)
            begin
               nxt_state   = ST_SEND;
               nxt_pos     = 8'h00;
               nxt_tx_crc  = CRC_INIT;
               nxt_tx_data = reply_byte(8'h00, CRC_INIT);
            end
            else
            begin
               nxt_state = ST_IDLE;
               nxt_drop  = 1'b1;
            end
         end
         ST_EXEC:
         begin
            // One coil or register per cycle keeps the write port single
            case (fc)
               FC_WR_COIL:
               begin
                  coil_we = 1'b1;
                  coil_wa = CW'(start);
                  coil_wd = (qty == COIL_ON);
               end
               FC_WR_COILS:
               begin
                  coil_we = 1'b1;
                  coil_wa = CW'(start + {9'h000, widx_ff});
                  coil_wd = rx_buf_ff[OFS_WDATA + {4'h0, widx_ff[6:3]}][widx_ff[2:0]];
               end
               FC_WR_REG:
               begin
                  reg_we = 1'b1;
                  reg_wa = RW'(start);
                  reg_wd = qty;
               end
               FC_WR_REGS:
               begin
                  reg_we = 1'b1;
                  reg_wa = RW'(start + {9'h000, widx_ff});
                  reg_wd = {rx_buf_ff[OFS_WDATA + {widx_ff, 1'b0}],
                            rx_buf_ff[OFS_WDATA + {widx_ff, 1'b0} + 8'h01]};
               end
               default:
               begin
                  nxt_state = ST_IDLE;
               end
            endcase
            if ({9'h000, widx_ff} + QTY_MIN >= qty_eff)
            begin
               nxt_state   = ST_SEND;
               nxt_pos     = 8'h00;
               nxt_tx_crc  = CRC_INIT;
               nxt_tx_data = reply_byte(8'h00, CRC_INIT);
            end
            else
               nxt_widx = widx_ff + 7'h01;
         end
         ST_SEND:
         begin
            if (tx_ready)
            begin
               if (pos_ff == body_len + 8'h01)
                  nxt_state = ST_IDLE;
               else
               begin
                  // Check is frozen once the body has gone out
                  if (pos_ff < body_len)
                     nxt_tx_crc = tx_crc_upd;
                  nxt_pos     = pos_ff + 8'h01;
                  nxt_tx_data = reply_byte(pos_ff + 8'h01, nxt_tx_crc);
               end
            end
         end
         default:
         begin
            nxt_state = ST_IDLE;
         end
      endcase
      // Leaving for idle rearms the receiver for the next frame
      if (state_ff != ST_IDLE && nxt_state == ST_IDLE)
      begin
         nxt_rx_cnt = 9'h000;
         nxt_rx_ovf = 1'b0;
         nxt_rx_crc = CRC_INIT;
      end
   end

   // Coil image next value
   always_comb
   begin
      nxt_coils = coils_ff;
      if (coil_we)
         nxt_coils[coil_wa] = coil_wd;
   end

   // ==========================================================
   // Control and coil registers
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_ff   <= ST_IDLE;
         rx_cnt_ff  <= 9'h000;
         rx_ovf_ff  <= 1'b0;
         rx_crc_ff  <= CRC_INIT;
         widx_ff    <= 7'h00;
         pos_ff     <= 8'h00;
         tx_data_ff <= 8'h00;
         tx_crc_ff  <= CRC_INIT;
         drop_ff    <= 1'b0;
         coils_ff   <= '0;
      end
      else
      begin
         state_ff   <= nxt_state;
         rx_cnt_ff  <= nxt_rx_cnt;
         rx_ovf_ff  <= nxt_rx_ovf;
         rx_crc_ff  <= nxt_rx_crc;
         widx_ff    <= nxt_widx;
         pos_ff     <= nxt_pos;
         tx_data_ff <= nxt_tx_data;
         tx_crc_ff  <= nxt_tx_crc;
         drop_ff    <= nxt_drop;
         coils_ff   <= nxt_coils;
      end
   end

   // Frame buffer needs no reset: only bytes below the count are read
   always_ff @(posedge core_clk)
   begin
      if (buf_we)
         rx_buf_ff[rx_cnt_ff[7:0]] <= rx_data;
   end

   // Holding registers, cleared at reset
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < REG_DEPTH; i++)
            regs_ff[i] <= 16'h0000;
      end
      else if (reg_we)
         regs_ff[reg_wa] <= reg_wd;
   end

   // Outputs
   assign tx_valid   = (state_ff == ST_SEND);
   assign tx_data    = tx_data_ff;
   assign coil_state = coils_ff;
   assign busy       = (state_ff != ST_IDLE);
   assign frame_drop = drop_ff;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   property p_bad_crc;
      (state_ff == ST_CHECK) && (rx_crc_ff != CRC_RESIDUE) |=> (state_ff == ST_IDLE) && drop_ff;
   endproperty
   a_bad_crc: assert property (p_bad_crc) else $error("bad check not dropped");

   property p_other_addr;
      (state_ff == ST_CHECK) && (rx_buf_ff[OFS_ADDR] != dev_addr) |=> !tx_valid [*2];
   endproperty
   a_other_addr: assert property (p_other_addr) else $error("foreign frame answered");

   property p_unknown_fc;
      (state_ff == ST_CHECK) && !supported |=> (state_ff == ST_IDLE) && $stable(coils_ff);
   endproperty
   a_unknown_fc: assert property (p_unknown_fc) else $error("unknown code acted on");

   property p_analog_no_coils;
      (state_ff == ST_CHECK) && !HAS_COILS && is_coil_fc |=> state_ff == ST_IDLE;
   endproperty
   a_analog_no_coils: assert property (p_analog_no_coils) else $error("coil code on analog");

   property p_bad_qty;
      (state_ff == ST_CHECK) && !range_ok |=> (state_ff == ST_IDLE) ##1 $stable(coils_ff);
   endproperty
   a_bad_qty: assert property (p_bad_qty) else $error("bad count changed state");

   property p_coil_nbytes;
      tx_valid && (fc == FC_RD_COILS) && (pos_ff == OFS_START_HI)
         |-> tx_data == 8'((qty + 16'h0007) >> 3);
   endproperty
   a_coil_nbytes: assert property (p_coil_nbytes) else $error("coil byte count wrong");

   property p_first_coil;
      tx_valid && (fc == FC_RD_COILS) && (pos_ff == READ_HDR_LEN)
         |-> tx_data[0] == coils_ff[CW'(start)];
   endproperty
   a_first_coil: assert property (p_first_coil) else $error("start coil not in bit 0");

   property p_pad_zero;
      tx_valid && (fc == FC_RD_COILS) && (pos_ff == body_len - 8'h01) && (qty[2:0] != 3'h0)
         |-> (tx_data >> qty[2:0]) == 8'h00;
   endproperty
   a_pad_zero: assert property (p_pad_zero) else $error("pad bits not zero");

   property p_reg_nbytes;
      tx_valid && is_read_reg && (pos_ff == OFS_START_HI) |-> tx_data == 8'(qty + qty);
   endproperty
   a_reg_nbytes: assert property (p_reg_nbytes) else $error("register byte count wrong");

   property p_echo;
      tx_valid && is_write && (pos_ff < ECHO_LEN) |-> tx_data == rx_buf_ff[pos_ff];
   endproperty
   a_echo: assert property (p_echo) else $error("write reply not an echo");

   c_read_coils: cover property (tx_valid && tx_ready && fc == FC_RD_COILS && pos_ff == body_len);
   c_write_coils: cover property (state_ff == ST_EXEC && fc == FC_WR_COILS && widx_ff == 7'h07);
   c_read_regs: cover property (tx_valid && tx_ready && is_read_reg && pos_ff == body_len);
   c_dropped: cover property (drop_ff);

endmodule : mrca_coil_access

// [core/mrca_pkg.sv]
// Package: constants and types shared by the Modbus RTU coil access block
package mrca_pkg;

   // ==========================================================
   // Function codes of the series
   localparam logic [7:0]  FC_RD_COILS   = 8'h01;
   localparam logic [7:0]  FC_RD_HOLD    = 8'h03;
   localparam logic [7:0]  FC_RD_INPUT   = 8'h04;
   localparam logic [7:0]  FC_WR_COIL    = 8'h05;
   localparam logic [7:0]  FC_WR_REG     = 8'h06;
   localparam logic [7:0]  FC_WR_COILS   = 8'h0F;
   localparam logic [7:0]  FC_WR_REGS    = 8'h10;

   // ==========================================================
   // Quantity limits and coil write values
   localparam logic [15:0] QTY_MIN       = 16'h0001;
   localparam logic [15:0] QTY_MAX       = 16'h0040;
   localparam logic [15:0] COIL_ON       = 16'hFF00;
   localparam logic [15:0] COIL_OFF      = 16'h0000;

   // ==========================================================
   // Frame check (reflected CRC-16, sent low byte first)
   localparam logic [15:0] CRC_INIT      = 16'hFFFF;
   localparam logic [15:0] CRC_POLY      = 16'hA001;
   localparam logic [15:0] CRC_RESIDUE   = 16'h0000;

   // ==========================================================
   // Byte offsets inside a request frame
   localparam logic [7:0]  OFS_ADDR      = 8'h00;
   localparam logic [7:0]  OFS_FC        = 8'h01;
   localparam logic [7:0]  OFS_START_HI  = 8'h02;
   localparam logic [7:0]  OFS_START_LO  = 8'h03;
   localparam logic [7:0]  OFS_QTY_HI    = 8'h04;
   localparam logic [7:0]  OFS_QTY_LO    = 8'h05;
   localparam logic [7:0]  OFS_NBYTES    = 8'h06;
   localparam logic [7:0]  OFS_WDATA     = 8'h07;

   // ==========================================================
   // Frame lengths, the unassigned address and the receive buffer depth
   localparam logic [7:0]  ECHO_LEN      = 8'h06;
   localparam logic [7:0]  READ_HDR_LEN  = 8'h03;
   localparam logic [15:0] LEN_FIXED     = 16'h0008;
   localparam logic [15:0] LEN_WMULTI    = 16'h0009;
   localparam logic [15:0] LEN_MIN       = 16'h0004;
   localparam logic [7:0]  ADDR_NONE     = 8'h00;
   localparam int          RX_DEPTH      = 256;

   // ==========================================================
   // Interpreter states
   typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_EXEC, ST_SEND} mrca_state_t;

endpackage : mrca_pkg

// [core/mrca_crc16_step.sv]
// One byte step of the frame check CRC, purely combinational
`timescale 1ns/1ps
module mrca_crc16_step
   import mrca_pkg::*;
(
   input  wire logic [15:0] crc_in,
   input  wire logic [7:0]  data_in,
   output logic [15:0]      crc_out
);

   // ==========================================================
   // Bit-serial update unrolled over one byte, LSB first
   always_comb
   begin
      crc_out = crc_in ^ {8'h00, data_in};
      for (int i = 0; i < 8; i++)
      begin
         crc_out = crc_out[0] ? ((crc_out >> 1) ^ CRC_POLY) : (crc_out >> 1);
      end
   end

endmodule : mrca_crc16_step

// [tb/mrca_host_model.sv]
// Host master model: sends request frames and gathers the reply bytes
`timescale 1ns/1ps
module mrca_host_model
   import mrca_pkg::*;
(
   input  wire logic       core_clk,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            rx_frame_end,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready,
   input  wire logic       frame_drop
);
   typedef logic [7:0] mrca_bq_t[$];
   mrca_bq_t   rsp;
   int         drop_cnt = 0;
   logic [7:0] lfsr_ff  = 8'h5a;

   initial
   begin
      rx_valid     = 1'b0;
      rx_data      = 8'h00;
      rx_frame_end = 1'b0;
      tx_ready     = 1'b0;
   end

   // ==========================================================
   // Frame check, reflected polynomial over the whole frame
   function automatic logic [15:0] crc16(input mrca_bq_t f);
      logic [15:0] c;
      c = CRC_INIT;
      foreach (f[i])
      begin
         c = c ^ {8'h00, f[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction : crc16

   // ==========================================================
   // Request sender; fields arrive already in wire order
   task automatic send(input mrca_bq_t f, input bit bad_crc);
      logic [15:0] c;
      c = crc16(f) ^ {15'h0000, bad_crc};
      f.push_back(c[7:0]);   // Low byte first
      f.push_back(c[15:8]);
      rsp.delete();
      foreach (f[i])
      begin
         @(posedge core_clk);
         rx_valid     <= 1'b1;
         rx_data      <= f[i];
         rx_frame_end <= (i == f.size() - 1);
      end
      @(posedge core_clk);
      rx_valid     <= 1'b0;
      rx_frame_end <= 1'b0;
      rx_data      <= ~f[f.size() - 1];        // Idle line never repeats the last byte
   endtask : send

   // ==========================================================
   // Reply sink with random stalls, so held bytes are exercised
   always @(posedge core_clk)
   begin
      if (tx_valid && tx_ready)
         rsp.push_back(tx_data);
      if (frame_drop)
         drop_cnt++;
      lfsr_ff  <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
      tx_ready <= lfsr_ff[0] | lfsr_ff[1];
   end
endmodule : mrca_host_model

// [tb/mrca_coil_access_tb_top.sv]
// Self-checking bench for the coil access interpreter
`timescale 1ns/1ps
module mrca_coil_access_tb_top;
   import mrca_pkg::*;
   typedef logic [7:0] mrca_bq_t[$];
   logic        core_clk = 1'b0;
   logic        reset_n  = 1'b0;
   logic [7:0]  dev_addr = 8'h01;
   logic        rx_valid, rx_frame_end, tx_valid, tx_ready, busy, frame_drop;
   logic [7:0]  rx_data, tx_data;
   logic [63:0] coil_state, img, an_coil_state;
   logic [31:0] seed = 32'h5d72_546f;
   int          error_cnt = 0;
   int          total_checks = 0;

   always #12.5 core_clk = ~core_clk;

   mrca_coil_access u_mrca_coil_access (.core_clk(core_clk), .reset_n(reset_n),
      .dev_addr(dev_addr), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_frame_end(rx_frame_end), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .coil_state(coil_state), .busy(busy), .frame_drop(frame_drop));

   // Analog variant listens to the same stream; coil codes must never reach its image
   mrca_coil_access #(.HAS_COILS(1'b0)) u_mrca_coil_access_analog (.core_clk(core_clk),
      .reset_n(reset_n), .dev_addr(dev_addr), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_frame_end(rx_frame_end), .tx_valid(), .tx_data(), .tx_ready(1'b1),
      .coil_state(an_coil_state), .busy(), .frame_drop());

   mrca_host_model u_host (.core_clk(core_clk), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_frame_end(rx_frame_end), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .frame_drop(frame_drop));

   // ==========================================================
   // Helpers: random source, frame builders, comparison
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function automatic mrca_bq_t hdr(input logic [7:0] fc, input int a, input int b);
      return {dev_addr, fc, 8'(a >> 8), 8'(a), 8'(b >> 8), 8'(b)};
   endfunction : hdr

   function automatic mrca_bq_t rd_exp(input int st, input int cnt);
      mrca_bq_t   q;
      logic [7:0] b;
      q = {dev_addr, FC_RD_COILS, 8'((cnt + 7) / 8)};
      for (int i = 0; i < (cnt + 7) / 8; i++)
      begin
         b = 8'h00;
         for (int k = 0; k < 8; k++)
            if (8 * i + k < cnt) b[k] = img[st + 8 * i + k];
         q.push_back(b);
      end
      return q;
   endfunction : rd_exp

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One request and its expected reply; an empty reply means a drop
   task automatic xact(input string what, input mrca_bq_t f, input bit bad, input mrca_bq_t e);
      int          n;
      int          d;
      logic [15:0] c;
      d = u_host.drop_cnt;
      u_host.send(f, bad);
      repeat (3) @(posedge core_clk);
      for (n = 0; busy !== 1'b0 && n < 3000; n++) @(posedge core_clk);
      if (e.size() > 0)
      begin
         c = u_host.crc16(e);
         e.push_back(c[7:0]);
         e.push_back(c[15:8]);
      end
      // A hang past the wait limit shows up here as a mismatch
      check({what, " idle"}, 64'(busy), 64'h0);
      check({what, " drop"}, 64'(u_host.drop_cnt - d), 64'(e.size() == 0));
      check({what, " length"}, 64'(u_host.rsp.size()), 64'(e.size()));
      foreach (e[i])
         if (i < u_host.rsp.size())
            check({what, " byte"}, 64'(u_host.rsp[i]), 64'(e[i]));
      check({what, " coils"}, coil_state, img);
      check({what, " analog coils"}, an_coil_state, 64'h0);
      $display("test %s done", what);
   endtask : xact

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test

   // Watchdog: the whole sequence needs far fewer cycles than this
   initial
   begin
      #1_000_000;
      error_cnt++;
      end_of_test();
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      int          st, cnt, nb;
      logic [15:0] v;
      mrca_bq_t    f, e, none;
      img = 64'h0;
      repeat (20) @(posedge core_clk);
      reset_n  <= 1'b1;
      dev_addr <= 8'(xs() % 254 + 1);
      @(posedge core_clk);
      // Known request check vector pins the model's CRC down independently
      check("crc_vector", 64'(u_host.crc16({8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h18})),
            64'h003C);
      xact("rd_reset", hdr(FC_RD_COILS, 0, 24), 1'b0, rd_exp(0, 24));
      // Random block writes, each read back at a random window
      for (int t = 0; t < 8; t++)
      begin
         st  = (t == 0) ? 0 : int'(xs() % 64);
         cnt = (t == 0) ? 64 : int'(xs() % (64 - st)) + 1;
         nb  = (cnt + 7) / 8;
         f   = hdr(FC_WR_COILS, st, cnt);
         e   = f;
         f.push_back(8'(nb));
         for (int i = 0; i < nb; i++) f.push_back(8'(xs()));
         for (int k = 0; k < cnt; k++) img[st + k] = f[7 + k / 8][k % 8];
         xact("wr_coils", f, 1'b0, e);
         st  = int'(xs() % 64);
         cnt = int'(xs() % (64 - st)) + 1;
         xact("rd_coils", hdr(FC_RD_COILS, st, cnt), 1'b0, rd_exp(st, cnt));
      end
      // Single coil toggled to its opposite value
      st = int'(xs() % 64);
      img[st] = ~img[st];
      f = hdr(FC_WR_COIL, st, img[st] ? COIL_ON : COIL_OFF);
      xact("wr_coil", f, 1'b0, f);
      // Refused frames leave everything untouched
      xact("bad_crc", hdr(FC_WR_COIL, st, img[st] ? COIL_OFF : COIL_ON), 1'b1, none);
      f = hdr(FC_WR_COIL, st, img[st] ? COIL_OFF : COIL_ON);
      f[0] = dev_addr + 8'h01;
      xact("wrong_addr", f, 1'b0, none);
      xact("cnt_zero", hdr(FC_RD_COILS, 0, 0), 1'b0, none);
      f = hdr(FC_WR_COILS, 0, 65);
      f.push_back(8'h09);
      repeat (9) f.push_back(8'hFF);
      xact("cnt_over", f, 1'b0, none);
      xact("bad_code", hdr(8'h02, 0, 8), 1'b0, none);
      xact("bad_val", hdr(FC_WR_COIL, st, 'h1234), 1'b0, none);
      xact("bound", hdr(FC_RD_COILS, 60, 8), 1'b0, none);
      // Register write, then both read codes
      v = 16'(xs());
      f = hdr(FC_WR_REG, 5, v);
      xact("wr_reg", f, 1'b0, f);
      xact("rd_hold", hdr(FC_RD_HOLD, 5, 1), 1'b0, {dev_addr, FC_RD_HOLD, 8'h02, v[15:8], v[7:0]});
      xact("rd_input", hdr(FC_RD_INPUT, 5, 1), 1'b0, {dev_addr, FC_RD_INPUT, 8'h02, v[15:8], v[7:0]});
      // Multi-register write next to the single one, then one read over all three
      f = {hdr(FC_WR_REGS, 6, 2), 8'h04, v[7:0], v[15:8], ~v[15:8], ~v[7:0]};
      xact("wr_regs", f, 1'b0, hdr(FC_WR_REGS, 6, 2));
      e = {dev_addr, FC_RD_HOLD, 8'h06, v[15:8], v[7:0], v[7:0], v[15:8], ~v[15:8], ~v[7:0]};
      xact("rd_regs", hdr(FC_RD_HOLD, 5, 3), 1'b0, e);
      end_of_test();
   end
endmodule : mrca_coil_access_tb_top
